// ### hdl/eitmr_pkg.sv
// shared constants of the eight-bit interval timer
package eitmr_pkg;
    // register indices on the cpu-side access port
    localparam logic [1:0] IDX_CYCLE_CMP  = 2'h0;
    localparam logic [1:0] IDX_DUTY_CMP   = 2'h1;
    localparam logic [1:0] IDX_MODE       = 2'h2;
    localparam logic [1:0] IDX_PORT_DIR   = 2'h3;
    // extra read-only view of the live counter, selected by CNT_RD_I
    // reset values
    localparam logic [7:0] RST_CMP        = 8'h00;
    localparam logic [7:0] RST_MODE       = 8'h00;
    localparam logic [7:0] RST_PORT_DIR   = 8'hFF;
    // timer_mode_control fields
    localparam int         BIT_OUT_EN     = 0;
    localparam int         BIT_MODE_LO    = 2;
    localparam int         BIT_MODE_HI    = 3;
    localparam int         BIT_CKS_LO     = 4;
    localparam int         BIT_CKS_HI     = 6;
    localparam int         BIT_CNT_EN     = 7;
    localparam logic [7:0] MODE_WR_MASK   = 8'hFD;
    localparam logic [1:0] MODE_INTERVAL  = 2'h0;
    localparam logic [1:0] MODE_PWM       = 2'h2;
    // count clock selections
    localparam logic [2:0] CKS_DIV1       = 3'h0;
    localparam logic [2:0] CKS_DIV2       = 3'h1;
    localparam logic [2:0] CKS_DIV4       = 3'h2;
    localparam logic [2:0] CKS_DIV16      = 3'h3;
    localparam logic [2:0] CKS_DIV64      = 3'h4;
    localparam logic [2:0] CKS_SLOW_OSC   = 3'h5;
    localparam logic [5:0] PRE_MASK_DIV2  = 6'h01;
    localparam logic [5:0] PRE_MASK_DIV4  = 6'h03;
    localparam logic [5:0] PRE_MASK_DIV16 = 6'h0F;
    localparam logic [5:0] PRE_MASK_DIV64 = 6'h3F;
    localparam logic [5:0] PRE_RST        = 6'h00;
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_ARM  = 3'b010,
        ST_RUN  = 3'b100
    } eitmr_state_t;
endpackage : eitmr_pkg

// ### hdl/eitmr_count_tick.sv
// count clock enable generator for the interval timer
`timescale 1ns/100ps
module eitmr_count_tick #(
    parameter int PRE_W = 6
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic [2:0] sel_i,
    input  wire logic       slow_tick_i,
    input  wire logic       slow_osc_halt_i,
    input  wire logic       standby_i,
    output logic            tick_o
);
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;

    function automatic logic hit(input logic [PRE_W-1:0] p, input logic [PRE_W-1:0] m);
        hit = ((p & m) == m);
    endfunction : hit

    always_comb begin
        next_pre = PRE_W'(pre + 1'b1);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pre <= eitmr_pkg::PRE_RST;
        end else begin
            pre <= next_pre;
        end
    end

    // system-clock derived rates stop in standby; the slow oscillator keeps going
    always_comb begin
        tick_o = 1'b0;
        unique case (sel_i)
            eitmr_pkg::CKS_DIV1:     tick_o = !standby_i;
            eitmr_pkg::CKS_DIV2:     tick_o = !standby_i && hit(pre, eitmr_pkg::PRE_MASK_DIV2);
            eitmr_pkg::CKS_DIV4:     tick_o = !standby_i && hit(pre, eitmr_pkg::PRE_MASK_DIV4);
            eitmr_pkg::CKS_DIV16:    tick_o = !standby_i && hit(pre, eitmr_pkg::PRE_MASK_DIV16);
            eitmr_pkg::CKS_DIV64:    tick_o = !standby_i && hit(pre, eitmr_pkg::PRE_MASK_DIV64);
            eitmr_pkg::CKS_SLOW_OSC: tick_o = slow_tick_i && !slow_osc_halt_i; // R17
            default:                 tick_o = 1'b0;
        endcase
    end
endmodule : eitmr_count_tick

// ### hdl/eitmr_timer.sv
// eight-bit interval timer with square-wave and pwm output
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: cycle match raises interrupt, clears counter
// R2: interval mode ignores duty compare entirely
// R3: output enable bit gives 50% square wave
// R4: counting begins on count enable write
// R5: interrupt repeats every compare+1 count clocks
// R6: counter advances within one count clock; the code swallows the first tick and first steps on the second
// R7: each cycle match inverts timer output
// R8: disable forces interrupt and output inactive
// R9: software never rewrites cycle compare while running
// R10: running duty write waits for old match
// R11: write colliding with match defers further
// R12: software rewrites duty before pwm restart
// R13: compare registers byte wide, reset zero
// R14: mode register bit/byte writable, reset zero
// R15: software clears direction bit for output
// R16: direction bits reset ones, zero drives
// R17: slow oscillator clock keeps counting in standby
// R18: counter steps per tick, restarts at zero
// R19: interrupt is one count-clock pulse
module eitmr_timer (
    input  wire logic       CLK_I,
    input  wire logic       SRST_I,
    input  wire logic [1:0] ADDR_I,
    input  wire logic       WR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       BIT_WR_I,
    input  wire logic [2:0] BIT_SEL_I,
    input  wire logic       BIT_VAL_I,
    input  wire logic       RD_I,
    input  wire logic       CNT_RD_I,
    input  wire logic       SLOW_TICK_I,
    input  wire logic       SLOW_OSC_HALT_I,
    input  wire logic       STANDBY_I,
    output logic [7:0]      RDATA_O,
    output logic            MATCH_IRQ_O,
    output logic            TIMER_OUT_O,
    output logic            SHARED_PIN_O,
    output logic            SHARED_PIN_OE_O
);
    logic [7:0]             cycle_compare;
    logic [7:0]             duty_compare;
    logic [7:0]             duty_latch;
    logic                   duty_pend;
    logic [7:0]             timer_mode_control;
    logic [7:0]             port_direction_reg;
    logic [7:0]             cnt;
    logic                   irq;
    logic                   tout;
    logic                   duty_phase;
    logic [7:0]             rdata;
    eitmr_pkg::eitmr_state_t state;

    logic [7:0]             next_cycle_compare;
    logic [7:0]             next_duty_compare;
    logic [7:0]             next_duty_latch;
    logic                   next_duty_pend;
    logic [7:0]             next_timer_mode_control;
    logic [7:0]             next_port_direction_reg;
    logic [7:0]             next_cnt;
    logic                   next_irq;
    logic                   next_tout;
    logic                   next_duty_phase;
    logic [7:0]             next_rdata;
    eitmr_pkg::eitmr_state_t next_state;

    logic                   tick;
    logic                   cnt_en;
    logic                   out_en;
    logic                   pwm;
    logic                   cyc_match;
    logic                   duty_match;
    logic                   duty_wr;

    function automatic logic [7:0] apply_wr(input logic [7:0] old, input logic byte_wr, input logic bit_wr,
                                             input logic [2:0] sel, input logic val, input logic [7:0] data);
        logic [7:0] res;
        res = old;
        if (byte_wr) begin
            res = data;
        end else if (bit_wr) begin
            res[sel] = val;
        end
        apply_wr = res;
    endfunction : apply_wr

    eitmr_count_tick #(
        .PRE_W (6)
    ) u_tick (
        .clk_i           (CLK_I),
        .srst_i          (SRST_I),
        .sel_i           (timer_mode_control[eitmr_pkg::BIT_CKS_HI:eitmr_pkg::BIT_CKS_LO]),
        .slow_tick_i     (SLOW_TICK_I),
        .slow_osc_halt_i (SLOW_OSC_HALT_I),
        .standby_i       (STANDBY_I),
        .tick_o          (tick)
    );

    assign cnt_en     = timer_mode_control[eitmr_pkg::BIT_CNT_EN];
    assign out_en     = timer_mode_control[eitmr_pkg::BIT_OUT_EN];
    assign pwm        = (timer_mode_control[eitmr_pkg::BIT_MODE_HI:eitmr_pkg::BIT_MODE_LO] == eitmr_pkg::MODE_PWM);
    assign cyc_match  = !duty_phase && (cnt == cycle_compare);
    // duty compare only exists in the pwm phase
    assign duty_match = duty_phase && pwm && (cnt == duty_compare); // R2
    assign duty_wr    = WR_I && (ADDR_I == eitmr_pkg::IDX_DUTY_CMP);

    //////////////////////////////////////////////////////////////////////////////
    // registers seen by the cpu
    always_comb begin
        next_cycle_compare      = cycle_compare;
        next_port_direction_reg = port_direction_reg;
        next_rdata              = rdata;
        // compare registers take byte writes only
        if (WR_I && ADDR_I == eitmr_pkg::IDX_CYCLE_CMP) begin
            // a running rewrite is accepted but gives an undefined period
            next_cycle_compare = WDATA_I; // R13 R9
        end
        next_timer_mode_control = apply_wr(timer_mode_control, WR_I && ADDR_I == eitmr_pkg::IDX_MODE,
                                           BIT_WR_I && ADDR_I == eitmr_pkg::IDX_MODE, BIT_SEL_I, BIT_VAL_I,
                                           WDATA_I) & eitmr_pkg::MODE_WR_MASK; // R14
        next_port_direction_reg = apply_wr(port_direction_reg, WR_I && ADDR_I == eitmr_pkg::IDX_PORT_DIR,
                                           BIT_WR_I && ADDR_I == eitmr_pkg::IDX_PORT_DIR, BIT_SEL_I,
                                           BIT_VAL_I, WDATA_I); // R16
        if (CNT_RD_I) begin
            next_rdata = cnt;
        end else if (RD_I) begin
            unique case (ADDR_I)
                eitmr_pkg::IDX_CYCLE_CMP: next_rdata = cycle_compare;
                eitmr_pkg::IDX_DUTY_CMP:  next_rdata = duty_pend ? duty_latch : duty_compare;
                eitmr_pkg::IDX_MODE:      next_rdata = timer_mode_control;
                eitmr_pkg::IDX_PORT_DIR:  next_rdata = port_direction_reg;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cycle_compare      <= eitmr_pkg::RST_CMP;
            timer_mode_control <= eitmr_pkg::RST_MODE;
            port_direction_reg <= eitmr_pkg::RST_PORT_DIR;
            rdata              <= eitmr_pkg::RST_CMP;
        end else begin
            cycle_compare      <= next_cycle_compare;
            timer_mode_control <= next_timer_mode_control;
            port_direction_reg <= next_port_direction_reg;
            rdata              <= next_rdata;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // counter, compare, output
    always_comb begin
        next_state        = state;
        next_cnt          = cnt;
        next_irq          = irq;
        next_tout         = tout;
        next_duty_phase   = duty_phase;
        next_duty_compare = duty_compare;
        next_duty_latch   = duty_latch;
        next_duty_pend    = duty_pend;
        if (duty_wr) begin
            if (state == eitmr_pkg::ST_STOP) begin
                next_duty_compare = WDATA_I; // R13
                next_duty_pend    = 1'b0;
            end else begin
                next_duty_latch = WDATA_I; // R10
                next_duty_pend  = 1'b1;
            end
        end
        if (!cnt_en) begin
            // levels already low simply stay low
            next_state      = eitmr_pkg::ST_STOP;
            next_irq        = 1'b0; // R8
            next_tout       = 1'b0; // R8
            next_duty_phase = 1'b0;
        end else begin
            unique case (state)
                eitmr_pkg::ST_STOP: begin
                    next_state = eitmr_pkg::ST_ARM; // R4
                    next_cnt   = 8'h00; // R18
                end
                eitmr_pkg::ST_ARM: begin
                    // the first tick is swallowed to align with the count clock
                    if (tick) begin
                        next_state = eitmr_pkg::ST_RUN; // R6
                    end
                end
                eitmr_pkg::ST_RUN: begin
                    if (tick) begin
                        next_irq = 1'b0; // R19
                        if (cyc_match) begin
                            next_cnt  = 8'h00; // R1 R5
                            next_irq  = 1'b1; // R1
                            next_tout = pwm ? 1'b1 : !tout; // R7
                            if (pwm) begin
                                next_duty_phase = 1'b1;
                            end
                        end else begin
                            next_cnt = 8'(cnt + 8'h01); // R18
                            if (duty_match) begin
                                next_tout       = 1'b0;
                                next_duty_phase = 1'b0;
                                // a colliding write keeps waiting for the next old-value match
                                if (duty_pend && !duty_wr) begin
                                    next_duty_compare = duty_latch; // R10 R11
                                    next_duty_pend    = 1'b0;
                                end
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state        <= eitmr_pkg::ST_STOP;
            cnt          <= 8'h00;
            irq          <= 1'b0;
            tout         <= 1'b0;
            duty_phase   <= 1'b0;
            duty_compare <= eitmr_pkg::RST_CMP;
            duty_latch   <= eitmr_pkg::RST_CMP;
            duty_pend    <= 1'b0;
        end else begin
            state        <= next_state;
            cnt          <= next_cnt;
            irq          <= next_irq;
            tout         <= next_tout;
            duty_phase   <= next_duty_phase;
            duty_compare <= next_duty_compare;
            duty_latch   <= next_duty_latch;
            duty_pend    <= next_duty_pend;
        end
    end

    assign RDATA_O         = rdata;
    assign MATCH_IRQ_O     = irq;
    assign TIMER_OUT_O     = out_en && tout; // R3
    assign SHARED_PIN_O    = out_en && tout;
    // pin drives only while software has selected output mode
    assign SHARED_PIN_OE_O = !port_direction_reg[0]; // R16 R15

    //////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    a_match_clears_cnt: assert property (state == eitmr_pkg::ST_RUN && cnt_en && tick && cyc_match // R1
        |=> cnt == 8'h00 && irq) else $error("cycle match did not clear counter and raise irq");
    a_duty_ignored: assert property (state == eitmr_pkg::ST_RUN && cnt_en && tick && !pwm && !cyc_match // R2
        |=> tout == $past(tout)) else $error("output moved without a cycle match in interval mode");
    a_out_gated: assert property (!out_en |-> !TIMER_OUT_O) // R3
        else $error("timer output active with output disabled");
    a_enable_starts: assert property (state == eitmr_pkg::ST_STOP && cnt_en // R4
        |=> state == eitmr_pkg::ST_ARM && cnt == 8'h00) else $error("enable did not arm the counter");
    a_first_advance: assert property (state == eitmr_pkg::ST_ARM && cnt_en && tick // R6
        |=> state == eitmr_pkg::ST_RUN && cnt == 8'h00) else $error("counter not running after one tick");
    a_square_toggle: assert property (state == eitmr_pkg::ST_RUN && cnt_en && tick && cyc_match && !pwm // R7
        |=> tout != $past(tout)) else $error("square wave did not invert on match");
    a_stop_idle: assert property (state != eitmr_pkg::ST_STOP && !cnt_en // R8
        |=> !irq && !tout && state == eitmr_pkg::ST_STOP) else $error("disable left irq or output active");
    a_duty_transfer: assert property (state == eitmr_pkg::ST_RUN && cnt_en && tick && duty_match // R10
        && duty_pend && !duty_wr |=> duty_compare == $past(duty_latch) && !duty_pend)
        else $error("pending duty value not transferred");
    a_duty_defer: assert property (state == eitmr_pkg::ST_RUN && cnt_en && tick && duty_match && duty_wr // R11
        |=> duty_pend && duty_compare == $past(duty_compare)) else $error("colliding duty write not deferred");
    a_count_step: assert property (state == eitmr_pkg::ST_RUN && cnt_en && tick && !cyc_match // R18
        |=> cnt == 8'($past(cnt) + 8'h01)) else $error("counter did not step by one");
    a_irq_pulse: assert property (irq && tick |=> !irq) // R19
        else $error("irq lasted beyond one count clock");

    c_interval_match: cover property (state == eitmr_pkg::ST_RUN && tick && cyc_match && !pwm && out_en);
    c_pwm_duty: cover property (state == eitmr_pkg::ST_RUN && tick && duty_match && duty_pend);
    c_stop_running: cover property (state == eitmr_pkg::ST_RUN && !cnt_en && irq);
endmodule : eitmr_timer

// ### sim/eitmr_timer_bench.sv
// self-checking bench of the eight-bit interval timer
`timescale 1ns/100ps
module eitmr_timer_bench;
    logic        clk;
    logic        srst;
    logic [1:0]  addr;
    logic        wr;
    logic [7:0]  wdata;
    logic        bit_wr;
    logic [2:0]  bit_sel;
    logic        bit_val;
    logic        rd;
    logic        cnt_rd;
    logic        slow_tick = 1'b0;
    logic        slow_halt;
    logic        standby;
    logic [7:0]  rdata;
    logic        irq;
    logic        tout;
    logic        pin;
    logic        pin_oe;
    logic        slow_on;
    int          bad_count;
    int          num_checks;
    int          cyc = 0;
    logic [31:0] seed;

    eitmr_timer i_eitmr_timer (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WR_I(wr), .WDATA_I(wdata),
        .BIT_WR_I(bit_wr), .BIT_SEL_I(bit_sel), .BIT_VAL_I(bit_val), .RD_I(rd), .CNT_RD_I(cnt_rd),
        .SLOW_TICK_I(slow_tick), .SLOW_OSC_HALT_I(slow_halt), .STANDBY_I(standby), .RDATA_O(rdata),
        .MATCH_IRQ_O(irq), .TIMER_OUT_O(tout), .SHARED_PIN_O(pin), .SHARED_PIN_OE_O(pin_oe));

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // slow ticks every third cycle keep the expected period exact
    always @(posedge clk) begin
        cyc <= cyc + 1;
        slow_tick <= slow_on && (cyc % 3 == 0);
        if (cyc == 30000) begin
            bad_count++;
            wrap_up();
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [7:0] mode_b(input logic en, input logic [2:0] cks, input logic [1:0] md,
                                          input logic oe);
        return {en, cks, md, 1'b0, oe};
    endfunction : mode_b

    // system clocks per count clock for each system-clock divider selection
    function automatic int cks_div(input logic [2:0] c);
        return (c == eitmr_pkg::CKS_DIV2) ? 2 : (c == eitmr_pkg::CKS_DIV4) ? 4 :
               (c == eitmr_pkg::CKS_DIV16) ? 16 : (c == eitmr_pkg::CKS_DIV64) ? 64 : 1;
    endfunction : cks_div

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask : chk1

    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    task automatic bwr(input logic [1:0] a, input logic [2:0] s, input logic v);
        @(posedge clk);
        bit_wr <= 1'b1;
        addr <= a;
        bit_sel <= s;
        bit_val <= v;
        @(posedge clk);
        bit_wr <= 1'b0;
    endtask : bwr

    task automatic rreg(input logic [1:0] a, input logic live, output logic [7:0] d);
        @(posedge clk);
        rd <= ~live;
        cnt_rd <= live;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        cnt_rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg

    // waits for a rising irq; checks the output level before and at it
    task automatic wait_irq(input int lim, input bit chk, input logic lb, input logic la, output int n);
        logic last;
        last = irq;
        for (n = 1; n <= lim; n++) begin
            @(posedge clk);
            #1;
            if (irq === 1'b1 && last === 1'b0) break;
            if (chk && irq === 1'b0) chk1(tout, lb, "output moved between matches");
            last = irq;
        end
        if (chk && n <= lim) chk1(tout, la, "output level at match");
    endtask : wait_irq

    task automatic hi_width(output int w);
        for (w = 0; w < 600 && tout !== 1'b1; w++) @(posedge clk) #1;
        for (w = 0; w < 600 && tout === 1'b1; w++) @(posedge clk) #1;
    endtask : hi_width

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    //////////////////////////////////////////////////////////////////////////////
    initial begin : main
        logic [7:0] d;
        logic [7:0] d2;
        logic [7:0] n_val;
        logic       oe;
        logic [2:0] cks;
        int         n;
        int         dv;
        {srst, wr, bit_wr, rd, cnt_rd, slow_halt, standby, slow_on} = 8'h80;
        {addr, wdata, bit_sel, bit_val} = '0;
        bad_count = 0;
        num_checks = 0;
        seed = 32'h62576935;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rreg(eitmr_pkg::IDX_CYCLE_CMP, 1'b0, d);
        chk8(d, eitmr_pkg::RST_CMP, "cycle compare reset");
        rreg(eitmr_pkg::IDX_DUTY_CMP, 1'b0, d);
        chk8(d, eitmr_pkg::RST_CMP, "duty compare reset");
        rreg(eitmr_pkg::IDX_MODE, 1'b0, d);
        chk8(d, eitmr_pkg::RST_MODE, "mode reset");
        rreg(eitmr_pkg::IDX_PORT_DIR, 1'b0, d);
        chk8(d, eitmr_pkg::RST_PORT_DIR, "direction reset");
        chk1(pin_oe, 1'b0, "pin driven after reset");
        bwr(eitmr_pkg::IDX_PORT_DIR, 3'h0, 1'b0);
        #1 chk1(pin_oe, 1'b1, "pin not driven");
        rreg(eitmr_pkg::IDX_PORT_DIR, 1'b0, d);
        chk8(d, 8'hFE, "direction bit write");
        wreg(eitmr_pkg::IDX_MODE, 8'h7F);
        rreg(eitmr_pkg::IDX_MODE, 1'b0, d);
        chk8(d, 8'h7F & eitmr_pkg::MODE_WR_MASK, "mode byte write");
        bwr(eitmr_pkg::IDX_MODE, 3'h4, 1'b0);
        rreg(eitmr_pkg::IDX_MODE, 1'b0, d);
        chk8(d, 8'h6D, "mode bit write");
        seed = lfsr_next(seed);
        wreg(eitmr_pkg::IDX_CYCLE_CMP, seed[7:0]);
        bwr(eitmr_pkg::IDX_CYCLE_CMP, 3'h0, ~seed[0]);
        rreg(eitmr_pkg::IDX_CYCLE_CMP, 1'b0, d);
        chk8(d, seed[7:0], "compare ignores bit write");
        // interval runs: compare 1, random and 0xFE, compare 1 and slowest divider
        for (int k = 0; k < 4; k++) begin
            seed = lfsr_next(seed);
            n_val = (k == 1) ? 8'h02 + 8'(seed[2:0]) : (k == 2) ? 8'hFE : 8'h01;
            cks = (k == 1) ? 3'(seed[5:4]) : (k == 3) ? eitmr_pkg::CKS_DIV64 : eitmr_pkg::CKS_DIV1;
            dv = cks_div(cks);
            oe = (k != 1);
            wreg(eitmr_pkg::IDX_DUTY_CMP, 8'(seed[9:8]));
            wreg(eitmr_pkg::IDX_CYCLE_CMP, n_val);
            wreg(eitmr_pkg::IDX_MODE, mode_b(1'b1, cks, eitmr_pkg::MODE_INTERVAL, oe));
            wait_irq((int'(n_val) + 2) * dv + 6, 1'b1, 1'b0, oe, n);
            chk1(n <= (int'(n_val) + 2) * dv + 1, 1'b1, "first match late");
            wait_irq(300, 1'b1, oe, 1'b0, n);
            chk8(8'(n), 8'((int'(n_val) + 1) * dv), "interval period");
            repeat (dv) @(posedge clk);
            #1 chk1(irq, 1'b0, "irq longer than one tick");
            wait_irq(300, 1'b1, 1'b0, oe, n);
            // the irq check above used up one count clock of this period
            chk8(8'(n + dv), 8'((int'(n_val) + 1) * dv), "interval period");
            chk1(pin, oe, "shared pin follows output");
            wreg(eitmr_pkg::IDX_MODE, mode_b(1'b0, cks, eitmr_pkg::MODE_INTERVAL, oe));
            repeat (2) @(posedge clk);
            #1 chk1(irq, 1'b0, "irq after disable");
            chk1(tout, 1'b0, "output after disable");
            rreg(eitmr_pkg::IDX_CYCLE_CMP, 1'b1, d);
            repeat (5) @(posedge clk);
            rreg(eitmr_pkg::IDX_CYCLE_CMP, 1'b1, d2);
            chk8(d2, d, "counter moved while disabled");
        end
        // slow oscillator during standby, then halted
        wreg(eitmr_pkg::IDX_CYCLE_CMP, 8'h03);
        standby <= 1'b1;
        slow_on <= 1'b1;
        wreg(eitmr_pkg::IDX_MODE, mode_b(1'b1, eitmr_pkg::CKS_SLOW_OSC, eitmr_pkg::MODE_INTERVAL, 1'b1));
        wait_irq(40, 1'b1, 1'b0, 1'b1, n);
        chk1(n <= 40, 1'b1, "no match in standby");
        wait_irq(40, 1'b1, 1'b1, 1'b0, n);
        chk8(8'(n), 8'h0C, "slow tick period");
        slow_halt <= 1'b1;
        wait_irq(40, 1'b0, 1'b0, 1'b0, n);
        chk1(n > 40, 1'b1, "counted with oscillator halted");
        wreg(eitmr_pkg::IDX_MODE, 8'h00);
        {standby, slow_on, slow_halt} <= 3'b000;
        // pwm: duty rewrite while running waits for the old match
        wreg(eitmr_pkg::IDX_CYCLE_CMP, 8'h09);
        wreg(eitmr_pkg::IDX_DUTY_CMP, 8'h02);
        wreg(eitmr_pkg::IDX_MODE, mode_b(1'b1, eitmr_pkg::CKS_DIV1, eitmr_pkg::MODE_PWM, 1'b1));
        hi_width(n);
        chk8(8'(n), 8'h03, "pwm active width");
        wreg(eitmr_pkg::IDX_DUTY_CMP, 8'h05);
        rreg(eitmr_pkg::IDX_DUTY_CMP, 1'b0, d);
        chk8(d, 8'h05, "pending duty readback");
        hi_width(n);
        chk8(8'(n), 8'h03, "duty changed before old match");
        hi_width(n);
        chk8(8'(n), 8'h06, "duty not transferred");
        // a write landing on the duty match edge waits one more period
        repeat (8) @(posedge clk);
        wreg(eitmr_pkg::IDX_DUTY_CMP, 8'h03);
        rreg(eitmr_pkg::IDX_DUTY_CMP, 1'b0, d);
        chk8(d, 8'h03, "colliding duty readback");
        hi_width(n);
        chk8(8'(n), 8'h06, "colliding duty applied early");
        hi_width(n);
        chk8(8'(n), 8'h04, "deferred duty not applied");
        wreg(eitmr_pkg::IDX_MODE, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk1(tout, 1'b0, "pwm output after disable");
        wrap_up();
    end : main
endmodule : eitmr_timer_bench
